// file: core/gpfn_pkg.sv
package gpfn_pkg;

    // ----------------------------------------------------------------
    // ports and widths
    // ----------------------------------------------------------------
    localparam int GPFN_NPORT = 5;
    localparam int GPFN_ADDR_W = 8;
    localparam logic [2:0] GPFN_PORT_A = 3'h0;
    localparam logic [2:0] GPFN_PORT_B = 3'h1;
    localparam logic [2:0] GPFN_PORT_C = 3'h2;
    localparam logic [2:0] GPFN_PORT_D = 3'h3;
    localparam logic [2:0] GPFN_PORT_E = 3'h4;
    localparam logic [31:0] GPFN_PORT_MASK [GPFN_NPORT] = '{
        32'h0000FFFF, 32'h00000FFF, 32'h000007FF, 32'h000001FF, 32'h01FFFFFF};
    localparam int GPFN_B_SYNC_BIT = 10;
    localparam int GPFN_B_SLEEP_BIT = 11;
    localparam logic [31:0] GPFN_B_GENERAL_MASK = 32'h000003FF;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] GPFN_OFS_AFSEL = 8'h00;
    localparam logic [7:0] GPFN_OFS_ARRANGE = 8'h04;
    localparam logic [7:0] GPFN_OFS_REQ = 8'h08;
    localparam logic [7:0] GPFN_OFS_PORT_BASE = 8'h20;
    localparam logic [7:0] GPFN_OFS_PORT_END = 8'hC0;
    localparam int GPFN_PORT_SHIFT = 5;
    // register index inside one port block
    localparam logic [2:0] GPFN_R_ENABLE = 3'h0;
    localparam logic [2:0] GPFN_R_EDGE = 3'h1;
    localparam logic [2:0] GPFN_R_POL = 3'h2;
    localparam logic [2:0] GPFN_R_MASK = 3'h3;
    localparam logic [2:0] GPFN_R_STATUS = 3'h4;
    localparam logic [2:0] GPFN_R_LEVEL = 3'h5;

    // ----------------------------------------------------------------
    // reset values and field positions
    // ----------------------------------------------------------------
    localparam logic [15:0] GPFN_AFSEL_RST = 16'h0000;
    localparam int GPFN_ARRANGE_BIT = 0;
    localparam logic GPFN_ARRANGE_RST = 1'b0;
    localparam logic [31:0] GPFN_ENABLE_RST = 32'h00000000;
    localparam logic [31:0] GPFN_CFG_RST = 32'h00000000;
    localparam logic [1:0] GPFN_RESP_OKAY = 2'h0;
    localparam logic [1:0] GPFN_RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int GPFN_CLK_MHZ = 100;
    localparam int GPFN_DEBOUNCE_US = 1000;
    localparam int GPFN_DEBOUNCE_CYC = GPFN_DEBOUNCE_US * GPFN_CLK_MHZ;

endpackage

// file: core/gpfn_debounce.sv
`timescale 1ns/1ps
module gpfn_debounce #(
    parameter int CYCLES = 100000
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // level in and filtered level out
    input wire logic level_in,
    output logic level_out
);
    import gpfn_pkg::*;

    logic [31:0] stable_cnt;

    // ----------------------------------------------------------------
    // accept a new level only after it held for CYCLES clocks
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            stable_cnt <= 32'h00000000;
            level_out <= 1'b0;
        end else if (level_in == level_out) begin
            stable_cnt <= 32'h00000000;
        end else if (stable_cnt >= 32'(CYCLES - 1)) begin
            stable_cnt <= 32'h00000000;
            level_out <= level_in;
        end else begin
            stable_cnt <= stable_cnt + 32'h00000001;
        end
    end

endmodule

// file: core/gpfn_trigger.sv
`timescale 1ns/1ps
module gpfn_trigger #(
    parameter int W = 32
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // synchronised levels and per-pin settings
    input wire logic [W-1:0] level,
    input wire logic [W-1:0] edge_sel,
    input wire logic [W-1:0] trigger_level_select,
    // qualified condition, one per pin
    output logic [W-1:0] cond
);
    import gpfn_pkg::*;

    logic [W-1:0] level_prev;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            level_prev <= '0;
        end else begin
            level_prev <= level;
        end
    end

    // edge: polarity picks rising or falling; level: polarity picks high or low
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (edge_sel[i]) begin
                cond[i] = trigger_level_select[i] ? (level[i] & ~level_prev[i])
                                                  : (~level[i] & level_prev[i]);
            end else begin
                cond[i] = trigger_level_select[i] ? level[i] : ~level[i];
            end
        end
    end

endmodule

// file: core/gpfn_top.sv
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module gpfn_top #(
    parameter int DEBOUNCE_CYCLES = gpfn_pkg::GPFN_DEBOUNCE_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // axi4-lite write address
    input wire logic [gpfn_pkg::GPFN_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [gpfn_pkg::GPFN_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pin levels from the pads
    input wire logic [15:0] pin_a,
    input wire logic [11:0] pin_b,
    input wire logic [10:0] pin_c,
    input wire logic [8:0] pin_d,
    input wire logic [24:0] pin_e,
    // pin function steering
    output logic [15:0] porta_alternate_function_select,
    output logic [15:0] gpio_enable_a,
    output logic [11:0] gpio_enable_b,
    output logic [10:0] gpio_enable_c,
    output logic [8:0] gpio_enable_d,
    output logic [24:0] gpio_enable_e,
    output logic port_e_pin_arrangement,
    output logic upper_address_bit_en,
    output logic can1_pins_en,
    // requests to the interrupt controller
    output logic port_a_irq,
    output logic sync_button_irq,
    output logic sleep_button_irq,
    output logic port_b_general_irq,
    output logic port_c_irq,
    output logic port_d_irq,
    output logic port_e_irq,
    output logic gpio_irq
);
    import gpfn_pkg::*;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic in_port_block(input logic [7:0] a);
        return (a >= GPFN_OFS_PORT_BASE) && (a < GPFN_OFS_PORT_END) && (a[4:2] <= GPFN_R_LEVEL)
            && (a[1:0] == 2'h0);
    endfunction

    function automatic logic [2:0] port_of(input logic [7:0] a);
        logic [7:0] d;
        d = (a - GPFN_OFS_PORT_BASE) >> GPFN_PORT_SHIFT;
        return d[2:0];
    endfunction

    function automatic logic [31:0] strb_mask(input logic [3:0] strb);
        return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction

    // ----------------------------------------------------------------
    // pin synchronisers and button debounce
    // ----------------------------------------------------------------
    logic [72:0] pin_meta;
    logic [72:0] pin_sync;
    logic sync_btn_level;
    logic sleep_btn_level;
    logic [31:0] level [GPFN_NPORT];

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= {pin_e, pin_d, pin_c, pin_b, pin_a};
            pin_sync <= pin_meta;
        end
    end

    gpfn_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_sync_btn (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .level_in(pin_sync[16 + GPFN_B_SYNC_BIT]),
        .level_out(sync_btn_level)
    );

    gpfn_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_sleep_btn (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .level_in(pin_sync[16 + GPFN_B_SLEEP_BIT]),
        .level_out(sleep_btn_level)
    );

    always_comb begin
        level[0] = {16'h0000, pin_sync[15:0]};
        level[1] = {20'h00000, sleep_btn_level, sync_btn_level, pin_sync[25:16]};
        level[2] = {21'h000000, pin_sync[38:28]};
        level[3] = {23'h000000, pin_sync[47:39]};
        level[4] = {7'h00, pin_sync[72:48]};
    end

    // ----------------------------------------------------------------
    // axi4-lite write channel
    // ----------------------------------------------------------------
    logic aw_held;
    logic w_held;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_fire;
    logic wr_ok;
    logic [2:0] wr_port;

    assign s_axi_awready = !aw_held;
    assign s_axi_wready = !w_held;
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign wr_port = port_of(wr_addr);
    assign wr_ok = (wr_addr == GPFN_OFS_AFSEL) || (wr_addr == GPFN_OFS_ARRANGE) || (wr_addr == GPFN_OFS_REQ)
        || in_port_block(wr_addr);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            aw_held <= 1'b0;
            wr_addr <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            wr_addr <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            w_held <= 1'b0;
            wr_data <= 32'h00000000;
            wr_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= GPFN_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? GPFN_RESP_OKAY : GPFN_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    logic [31:0] port_en [GPFN_NPORT];
    logic [31:0] edge_sel [GPFN_NPORT];
    logic [31:0] trig_pol [GPFN_NPORT];
    logic [31:0] irq_mask [GPFN_NPORT];
    logic [31:0] irq_stat [GPFN_NPORT];

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            porta_alternate_function_select <= GPFN_AFSEL_RST;
            port_e_pin_arrangement <= GPFN_ARRANGE_RST;
        end else if (wr_fire && wr_addr == GPFN_OFS_AFSEL) begin
            porta_alternate_function_select <= 16'(merge_strb({16'h0000, porta_alternate_function_select},
                                                              wr_data, wr_strb));
        end else if (wr_fire && wr_addr == GPFN_OFS_ARRANGE && wr_strb[0]) begin
            port_e_pin_arrangement <= wr_data[GPFN_ARRANGE_BIT];
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            for (int p = 0; p < GPFN_NPORT; p++) begin
                port_en[p] <= GPFN_ENABLE_RST;
                edge_sel[p] <= GPFN_CFG_RST;
                trig_pol[p] <= GPFN_CFG_RST;
                irq_mask[p] <= GPFN_CFG_RST;
            end
        end else if (wr_fire && in_port_block(wr_addr)) begin
            unique case (wr_addr[4:2])
                GPFN_R_ENABLE: port_en[wr_port] <= merge_strb(port_en[wr_port], wr_data, wr_strb)
                    & GPFN_PORT_MASK[wr_port];
                GPFN_R_EDGE: edge_sel[wr_port] <= merge_strb(edge_sel[wr_port], wr_data, wr_strb)
                    & GPFN_PORT_MASK[wr_port];
                GPFN_R_POL: trig_pol[wr_port] <= merge_strb(trig_pol[wr_port], wr_data, wr_strb)
                    & GPFN_PORT_MASK[wr_port];
                GPFN_R_MASK: irq_mask[wr_port] <= merge_strb(irq_mask[wr_port], wr_data, wr_strb)
                    & GPFN_PORT_MASK[wr_port];
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // pin function steering
    // ----------------------------------------------------------------
    assign gpio_enable_a = port_en[0][15:0];
    assign gpio_enable_b = port_en[1][11:0];
    assign gpio_enable_c = port_en[2][10:0];
    assign gpio_enable_d = port_en[3][8:0];
    assign gpio_enable_e = port_en[4][24:0];
    assign upper_address_bit_en = !port_e_pin_arrangement;
    assign can1_pins_en = port_e_pin_arrangement;

    // ----------------------------------------------------------------
    // trigger qualification and sticky status
    // ----------------------------------------------------------------
    logic [159:0] lvl_flat;
    logic [159:0] edge_flat;
    logic [159:0] pol_flat;
    logic [159:0] cond_flat;

    always_comb begin
        for (int p = 0; p < GPFN_NPORT; p++) begin
            lvl_flat[32*p +: 32] = level[p];
            edge_flat[32*p +: 32] = edge_sel[p];
            pol_flat[32*p +: 32] = trig_pol[p];
        end
    end

    gpfn_trigger #(.W(160)) u_trigger (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .level(lvl_flat),
        .edge_sel(edge_flat),
        .trigger_level_select(pol_flat),
        .cond(cond_flat)
    );

    // set wins over a write-one-to-clear in the same cycle
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            for (int p = 0; p < GPFN_NPORT; p++) begin
                irq_stat[p] <= 32'h00000000;
            end
        end else begin
            for (int p = 0; p < GPFN_NPORT; p++) begin
                if (wr_fire && in_port_block(wr_addr) && wr_addr[4:2] == GPFN_R_STATUS && wr_port == 3'(p)) begin
                    irq_stat[p] <= ((irq_stat[p] & ~(wr_data & strb_mask(wr_strb))) | cond_flat[32*p +: 32])
                        & GPFN_PORT_MASK[p];
                end else begin
                    irq_stat[p] <= (irq_stat[p] | cond_flat[32*p +: 32]) & GPFN_PORT_MASK[p];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // request grouping
    // ----------------------------------------------------------------
    logic [31:0] pend [GPFN_NPORT];

    always_comb begin
        for (int p = 0; p < GPFN_NPORT; p++) begin
            pend[p] = irq_stat[p] & irq_mask[p];
        end
    end

    assign port_a_irq = |pend[0];
    assign sync_button_irq = pend[1][GPFN_B_SYNC_BIT];
    assign sleep_button_irq = pend[1][GPFN_B_SLEEP_BIT];
    assign port_b_general_irq = |(pend[1] & GPFN_B_GENERAL_MASK);
    assign port_c_irq = |pend[2];
    assign port_d_irq = |pend[3];
    assign port_e_irq = |pend[4];
    assign gpio_irq = port_a_irq | sync_button_irq | sleep_button_irq | port_b_general_irq
        | port_c_irq | port_d_irq | port_e_irq;

    // ----------------------------------------------------------------
    // axi4-lite read channel
    // ----------------------------------------------------------------
    logic [2:0] rd_port;
    logic [31:0] rd_word;
    logic rd_ok;

    assign s_axi_arready = !s_axi_rvalid;
    assign rd_port = port_of(s_axi_araddr);

    always_comb begin
        rd_word = 32'h00000000;
        rd_ok = 1'b1;
        if (s_axi_araddr == GPFN_OFS_AFSEL) begin
            rd_word = {16'h0000, porta_alternate_function_select};
        end else if (s_axi_araddr == GPFN_OFS_ARRANGE) begin
            rd_word = {31'h00000000, port_e_pin_arrangement};
        end else if (s_axi_araddr == GPFN_OFS_REQ) begin
            rd_word = {25'h0000000, port_e_irq, port_d_irq, port_c_irq, port_b_general_irq,
                       sleep_button_irq, sync_button_irq, port_a_irq};
        end else if (in_port_block(s_axi_araddr)) begin
            unique case (s_axi_araddr[4:2])
                GPFN_R_ENABLE: rd_word = port_en[rd_port];
                GPFN_R_EDGE: rd_word = edge_sel[rd_port];
                GPFN_R_POL: rd_word = trig_pol[rd_port];
                GPFN_R_MASK: rd_word = irq_mask[rd_port];
                GPFN_R_STATUS: rd_word = irq_stat[rd_port];
                default: rd_word = level[rd_port];
            endcase
        end else begin
            rd_ok = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= GPFN_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? GPFN_RESP_OKAY : GPFN_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// file: test/gpfn_pins_model.sv
`timescale 1ns/1ps
module gpfn_pins_model (
    // clock
    input logic clk_sys,
    // pad levels
    output logic [15:0] pin_a,
    output logic [11:0] pin_b,
    output logic [10:0] pin_c,
    output logic [8:0] pin_d,
    output logic [24:0] pin_e
);
    // ----------------------------------------------------------------
    // pins and buttons
    // ----------------------------------------------------------------
    initial {pin_a, pin_b, pin_c, pin_d, pin_e} = '0;
    // button pins chatter twice before they settle
    task automatic drive(input int p, input int b, input logic v);
        int n;
        n = (p == 1 && b >= 10) ? 3 : 1;
        repeat (n) begin
            @(posedge clk_sys);
            case (p)
                0: pin_a[b] <= v;
                1: pin_b[b] <= v;
                2: pin_c[b] <= v;
                3: pin_d[b] <= v;
                default: pin_e[b] <= v;
            endcase
            v = !v;
        end
    endtask
endmodule

// file: test/gpfn_top_asserts.sv
`timescale 1ns/1ps
module gpfn_top_asserts (
    // clock and reset
    input logic clk_sys,
    input logic arst_n,
    // steering and bus answer
    input logic s_axi_bvalid,
    input logic [15:0] porta_alternate_function_select,
    input logic [24:0] gpio_enable_e,
    input logic port_e_pin_arrangement,
    input logic upper_address_bit_en,
    input logic can1_pins_en,
    // requests
    input logic port_a_irq,
    input logic sync_button_irq,
    input logic sleep_button_irq,
    input logic port_b_general_irq,
    input logic port_c_irq,
    input logic port_d_irq,
    input logic port_e_irq,
    input logic gpio_irq
);
    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    property p_afsel; $changed(porta_alternate_function_select) |-> $rose(s_axi_bvalid); endproperty
    a_afsel: assert property (p_afsel) else $error("select moved without a write");
    property p_arr; $changed(port_e_pin_arrangement) |-> $rose(s_axi_bvalid); endproperty
    a_arr: assert property (p_arr) else $error("arrangement moved without a write");
    property p_upper; !port_e_pin_arrangement |-> upper_address_bit_en && !can1_pins_en; endproperty
    a_upper: assert property (p_upper) else $error("cleared arrangement wrong");
    property p_can; port_e_pin_arrangement |-> can1_pins_en && !upper_address_bit_en; endproperty
    a_can: assert property (p_can) else $error("set arrangement wrong");
    property p_en; $changed(gpio_enable_e) |-> $rose(s_axi_bvalid); endproperty
    a_en: assert property (p_en) else $error("enable moved without a write");
    property p_sum; gpio_irq == (port_a_irq || sync_button_irq || sleep_button_irq ||
        port_b_general_irq || port_c_irq || port_d_irq || port_e_irq); endproperty
    a_sum: assert property (p_sum) else $error("summary request wrong");
    property p_fall_a; $fell(port_a_irq) |-> $rose(s_axi_bvalid); endproperty
    a_fall_a: assert property (p_fall_a) else $error("port a request dropped alone");
    property p_fall_sl; $fell(sleep_button_irq) |-> $rose(s_axi_bvalid); endproperty
    a_fall_sl: assert property (p_fall_sl) else $error("sleep request dropped alone");
    property p_fall_sy; $fell(sync_button_irq) |-> $rose(s_axi_bvalid); endproperty
    a_fall_sy: assert property (p_fall_sy) else $error("sync request dropped alone");
    property p_fall_g; $fell(port_b_general_irq) |-> $rose(s_axi_bvalid); endproperty
    a_fall_g: assert property (p_fall_g) else $error("general request dropped alone");
    c_sleep: cover property ($rose(sleep_button_irq));
    c_e: cover property ($rose(port_e_irq));
    c_arr: cover property ($rose(port_e_pin_arrangement));
endmodule

// file: test/test_gpfn_top.sv
`timescale 1ns/1ps
module test_gpfn_top;
    import gpfn_pkg::*;
    // ----------------------------------------------------------------
    // bench
    // ----------------------------------------------------------------
    logic clk_sys = 0;
    logic arst_n = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, d, x;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [1:0] r;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [15:0] pin_a, porta_alternate_function_select, gpio_enable_a;
    wire [11:0] pin_b, gpio_enable_b;
    wire [10:0] pin_c, gpio_enable_c;
    wire [8:0] pin_d, gpio_enable_d;
    wire [24:0] pin_e, gpio_enable_e;
    wire port_e_pin_arrangement, upper_address_bit_en, can1_pins_en, gpio_irq;
    wire port_a_irq, sync_button_irq, sleep_button_irq, port_b_general_irq, port_c_irq, port_d_irq, port_e_irq;
    wire [6:0] irqv = {port_e_irq, port_d_irq, port_c_irq, port_b_general_irq, sleep_button_irq,
        sync_button_irq, port_a_irq};
    int err_total = 0, n_tests = 0, cyc = 0;
    logic [31:0] seed = 17155;
    int gp[7] = '{0, 1, 1, 1, 2, 3, 4};
    int gb[7] = '{15, 10, 11, 3, 10, 8, 24};
    gpfn_top #(.DEBOUNCE_CYCLES(4)) dut_u (.*);
    gpfn_pins_model pm_u (.*);
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 8000) begin
            err_total++;
            finish_test;
        end
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic aw, w, b;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        b = 1'b0;
        while (!b) begin
            @(negedge clk_sys);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            rs = s_axi_bresp;
            @(posedge clk_sys);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic ar, b;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        b = 1'b0;
        while (!b) begin
            @(negedge clk_sys);
            ar = s_axi_arvalid && s_axi_arready;
            b = s_axi_rvalid;
            v = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge clk_sys);
            if (ar) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
    endtask
    // arm one pin with the given trigger, fire it, then clear it again
    task automatic trig(input int p, input int b, input int e, input int pl, input int idx);
        logic [7:0] a;
        logic [31:0] m;
        a = GPFN_OFS_PORT_BASE + 8'(p << GPFN_PORT_SHIFT);
        m = 32'h1 << b;
        wr(a + 8'h04, e ? m : 32'h0, r);
        wr(a + 8'h08, pl ? m : 32'h0, r);
        pm_u.drive(p, b, !pl);
        repeat (12) @(posedge clk_sys);
        wr(a + 8'h10, m, r);
        wr(a + 8'h0C, m, r);
        chk(irqv, 0);
        pm_u.drive(p, b, pl);
        if (p == 1 && b >= 10) begin
            repeat (4) @(negedge clk_sys);
            chk(irqv, 0);
        end
        for (int i = 0; i < 30 && gpio_irq !== 1'b1; i++) @(negedge clk_sys);
        chk(irqv, 32'h1 << idx);
        rd(GPFN_OFS_REQ, d, r);
        chk(d, 32'h1 << idx);
        rd(a + 8'h14, d, r);
        chk(d, pl ? m : 32'h0);
        pm_u.drive(p, b, !pl);
        repeat (12) @(posedge clk_sys);
        wr(a + 8'h10, m, r);
        chk(irqv, 0);
        wr(a + 8'h0C, 32'h0, r);
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        arst_n <= 1'b1;
        rd(GPFN_OFS_AFSEL, d, r);
        chk(d, 32'(GPFN_AFSEL_RST));
        rd(GPFN_OFS_ARRANGE, d, r);
        chk(d, 0);
        x = rnd();
        wr(GPFN_OFS_AFSEL, x, r);
        rd(GPFN_OFS_AFSEL, d, r);
        chk(d, x & 32'h0000FFFF);
        chk(porta_alternate_function_select, x[15:0]);
        wr(GPFN_OFS_ARRANGE, 32'h1, r);
        rd(GPFN_OFS_ARRANGE, d, r);
        chk(d, 1);
        chk({upper_address_bit_en, can1_pins_en}, 2'h1);
        wr(GPFN_OFS_ARRANGE, 32'hFFFFFFFE, r);
        chk({upper_address_bit_en, can1_pins_en}, 2'h2);
        $display("test function select done");
        for (int p = 0; p < GPFN_NPORT; p++) begin
            rd(GPFN_OFS_PORT_BASE + 8'(p << GPFN_PORT_SHIFT), d, r);
            chk(d, GPFN_ENABLE_RST);
            x = rnd();
            wr(GPFN_OFS_PORT_BASE + 8'(p << GPFN_PORT_SHIFT), x, r);
            chk(r, GPFN_RESP_OKAY);
            rd(GPFN_OFS_PORT_BASE + 8'(p << GPFN_PORT_SHIFT), d, r);
            chk(d, x & GPFN_PORT_MASK[p]);
            chk(p == 0 ? gpio_enable_a : p == 1 ? gpio_enable_b : p == 2 ? gpio_enable_c
                : p == 3 ? gpio_enable_d : gpio_enable_e, x & GPFN_PORT_MASK[p]);
        end
        chk(gpio_enable_e, x[24:0]);
        wr(8'hFC, x, r);
        chk(r, GPFN_RESP_SLVERR);
        rd(8'hFC, d, r);
        chk(r, GPFN_RESP_SLVERR);
        $display("test enables done");
        for (int i = 0; i < 7; i++) trig(gp[i], gb[i], 1, 1, i);
        $display("test groups done");
        for (int m = 0; m < 4; m++) trig(0, 0, m >> 1, m & 1, 0);
        $display("test trigger modes done");
        finish_test;
    end
endmodule
bind gpfn_top gpfn_top_asserts chk_u (.clk_sys, .arst_n, .s_axi_bvalid, .porta_alternate_function_select,
    .gpio_enable_e, .port_e_pin_arrangement, .upper_address_bit_en, .can1_pins_en, .port_a_irq,
    .sync_button_irq, .sleep_button_irq, .port_b_general_irq, .port_c_irq, .port_d_irq, .port_e_irq, .gpio_irq);
